// ---- inc/cpu_int_pkg.sv ----
// Constants, types and register map of the interrupt and serial bit unit.
// Assumes a single 20 MHz clock and an AXI4-Lite master on the register side.
//
// Functional notes
// - Five request inputs: one unmaskable, four maskable
// - Three restart inputs each own a mask
// - Maskable taken only when enabled and unmasked
// - Unmaskable input ignores enable and masks
// - Two lower restart inputs are level sensitive
// - Rising edge latches top restart request
// - Edge latch cleared by service, mask-set or reset
// - Edge latch sets even while masked
// - Fixed priority: unmaskable, edge, high, low, general
// - Priority ignores currently running handler
// - Unmaskable re-armed only by a low level
// - Any service clears global enable
// - First mask-read after unmaskable shows saved enable
// - Mask-read after maskable service shows disabled
// - Mask-read samples serial in; mask-set drives out
// - Serial input bit lands in bit 7
// - Vectors 24H, 3CH, 34H, 2CH; counter pushed first
// - All request inputs synchronised before evaluation
// - Reset clears global enable

package cpu_int_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_MASK_SET = 8'h00;
   localparam logic [7:0] OFF_MASK_READ = 8'h04;
   localparam logic [7:0] OFF_ENABLE = 8'h08;

   // ----------------------------------------
   // Mask-set word fields
   // ----------------------------------------
   localparam int SET_MASK_LSB = 0;
   localparam int SET_MASK_ENABLE = 3;
   localparam int SET_EDGE_CLEAR = 4;
   localparam int SET_SERIAL_ENABLE = 6;
   localparam int SET_SERIAL_DATA = 7;

   // ----------------------------------------
   // Mask-read word fields
   // ----------------------------------------
   localparam int RD_MASK_LSB = 0;
   localparam int RD_ENABLE = 3;
   localparam int RD_PEND_LO = 4;
   localparam int RD_PEND_HI = 5;
   localparam int RD_PEND_EDGE = 6;
   localparam int RD_SERIAL_BIT = 7;

   // Enable word: bit 0 set enables, clear disables
   localparam int EN_BIT = 0;

   // Mask bit order inside the three-bit mask
   localparam int MASK_LO = 0;
   localparam int MASK_HI = 1;
   localparam int MASK_EDGE = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [2:0] MASK_RESET = 3'h7;
   localparam logic SERIAL_OUT_RESET = 1'h0;

   // ----------------------------------------
   // Restart vectors
   // ----------------------------------------
   localparam logic [7:0] VEC_NMI = 8'h24;
   localparam logic [7:0] VEC_EDGE = 8'h3C;
   localparam logic [7:0] VEC_LEVEL_HI = 8'h34;
   localparam logic [7:0] VEC_LEVEL_LO = 8'h2C;
   // General request: the core fetches the vector from outside
   localparam logic [7:0] VEC_NONE = 8'h00;

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_NMI,
      SRC_EDGE,
      SRC_LEVEL_HI,
      SRC_LEVEL_LO,
      SRC_GENERAL
   } src_e;

   typedef struct packed {
      logic nmi;
      logic edge_rst;
      logic level_hi;
      logic level_lo;
      logic general;
   } int_pins_s;

endpackage : cpu_int_pkg

// ---- verilog/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins are free running and unrelated to aclk.
`timescale 1ns/10ps

module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_q
);

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1");
   end

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] level_d;

   // Stage 1 feeds stage 2 only; the filter looks at stages 2 and 3
   assign agree = ~(stage2_q ^ stage3_q);
   assign level_d = (agree & stage3_q) | (~agree & level_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
         level_q <= '0;
      end else begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         level_q <= level_d;
      end
   end

endmodule : pin_sync

// ---- verilog/cpu_int_unit.sv ----
// Interrupt recognition, priority and serial bit unit with AXI4-Lite registers.
// Assumes the core pulses the acknowledge for one cycle when it takes the
// presented request, and that request pins are asynchronous to aclk.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps

module cpu_int_unit #(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire cpu_int_pkg::int_pins_s int_pins,
   input wire logic serial_bit_in,
   input wire logic int_acknowledge_strobe,
   output logic int_request,
   output logic [7:0] int_vector,
   output logic int_general,
   output logic serial_bit_out
);

   if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("cpu_int_unit needs ADDR_W between 4 and 32");
   end

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   logic [5:0] sync_level;
   cpu_int_pkg::int_pins_s pins_s;
   logic serial_s;

   pin_sync #(
      .WIDTH(6)
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({int_pins, serial_bit_in}),
      .level_q(sync_level)
   );

   assign pins_s = cpu_int_pkg::int_pins_s'(sync_level[5:1]);
   assign serial_s = sync_level[0];

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic ie_q;
   logic saved_ie_q;
   logic report_saved_q;
   logic [2:0] mask_q;
   logic edge_latch_q;
   logic edge_prev_q;
   logic nmi_armed_q;
   logic serial_out_q;
   cpu_int_pkg::src_e src_q;

   // ----------------------------------------
   // Bus slave state
   // ----------------------------------------
   logic aw_got_q;
   logic w_got_q;
   logic ar_got_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [ADDR_W-1:0] ar_addr_q;
   logic [7:0] w_byte_q;
   logic w_lane0_q;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   logic wr_fire;
   logic rd_fire;
   logic sel_set_w;
   logic sel_read_w;
   logic sel_en_w;
   logic sel_set_r;
   logic sel_read_r;
   logic sel_en_r;
   logic wr_mapped;
   logic rd_mapped;
   logic set_fire;
   logic en_fire;
   logic read_fire;

   assign wr_fire = aw_got_q & w_got_q & ~bvalid;
   assign rd_fire = ar_got_q & ~rvalid;
   assign sel_set_w = aw_addr_q == ADDR_W'(cpu_int_pkg::OFF_MASK_SET);
   assign sel_read_w = aw_addr_q == ADDR_W'(cpu_int_pkg::OFF_MASK_READ);
   assign sel_en_w = aw_addr_q == ADDR_W'(cpu_int_pkg::OFF_ENABLE);
   assign sel_set_r = ar_addr_q == ADDR_W'(cpu_int_pkg::OFF_MASK_SET);
   assign sel_read_r = ar_addr_q == ADDR_W'(cpu_int_pkg::OFF_MASK_READ);
   assign sel_en_r = ar_addr_q == ADDR_W'(cpu_int_pkg::OFF_ENABLE);
   // Mask-read word is read only; a write to it is an error
   assign wr_mapped = sel_set_w | sel_en_w;
   assign rd_mapped = sel_set_r | sel_read_r | sel_en_r;
   // All fields live in byte 0, so lane 0 alone carries the effect
   assign set_fire = wr_fire & w_lane0_q & sel_set_w;
   assign en_fire = wr_fire & w_lane0_q & sel_en_w;
   assign read_fire = rd_fire & sel_read_r;

   // ----------------------------------------
   // Request qualification
   // ----------------------------------------
   logic edge_rise;
   logic nmi_active;
   logic edge_active;
   logic hi_active;
   logic lo_active;
   logic gen_active;
   logic ack_take;
   logic take_nmi;
   logic take_edge;
   logic edge_clear_cmd;

   assign edge_rise = pins_s.edge_rst & ~edge_prev_q;
   assign nmi_active = nmi_armed_q & pins_s.nmi;
   assign edge_active = edge_latch_q & ~mask_q[cpu_int_pkg::MASK_EDGE] & ie_q;
   assign hi_active = pins_s.level_hi & ~mask_q[cpu_int_pkg::MASK_HI] & ie_q;
   assign lo_active = pins_s.level_lo & ~mask_q[cpu_int_pkg::MASK_LO] & ie_q;
   assign gen_active = pins_s.general & ie_q;

   // Acknowledge only counts against the request being presented
   assign ack_take = int_acknowledge_strobe & int_request;
   assign take_nmi = ack_take & (src_q == cpu_int_pkg::SRC_NMI);
   assign take_edge = ack_take & (src_q == cpu_int_pkg::SRC_EDGE);
   assign edge_clear_cmd = set_fire & w_byte_q[cpu_int_pkg::SET_EDGE_CLEAR];

   // ----------------------------------------
   // Fixed priority select
   // ----------------------------------------
   cpu_int_pkg::src_e src_d;
   logic [7:0] vector_d;
   logic req_d;

   // No record of the running handler, so nesting follows re-enable alone
   assign src_d = nmi_active ? cpu_int_pkg::SRC_NMI :
                  edge_active ? cpu_int_pkg::SRC_EDGE :
                  hi_active ? cpu_int_pkg::SRC_LEVEL_HI :
                  lo_active ? cpu_int_pkg::SRC_LEVEL_LO :
                  gen_active ? cpu_int_pkg::SRC_GENERAL :
                  cpu_int_pkg::SRC_NONE;

   assign vector_d = nmi_active ? cpu_int_pkg::VEC_NMI :
                     edge_active ? cpu_int_pkg::VEC_EDGE :
                     hi_active ? cpu_int_pkg::VEC_LEVEL_HI :
                     lo_active ? cpu_int_pkg::VEC_LEVEL_LO :
                     cpu_int_pkg::VEC_NONE;

   // Drop the request for the cycle after an acknowledge so the stale
   // winner cannot be taken twice; levels re-qualify from live pins
   assign req_d = (src_d != cpu_int_pkg::SRC_NONE) & ~ack_take;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] read_word;
   logic [31:0] set_word;
   logic [31:0] en_word;
   logic [31:0] rd_word;
   logic shown_ie;

   // First read after an unmaskable service shows the enable it interrupted
   assign shown_ie = report_saved_q ? saved_ie_q : ie_q;

   always_comb begin
      read_word = '0;
      read_word[cpu_int_pkg::RD_MASK_LSB +: 3] = mask_q;
      read_word[cpu_int_pkg::RD_ENABLE] = shown_ie;
      read_word[cpu_int_pkg::RD_PEND_LO] = pins_s.level_lo;
      read_word[cpu_int_pkg::RD_PEND_HI] = pins_s.level_hi;
      read_word[cpu_int_pkg::RD_PEND_EDGE] = edge_latch_q;
      read_word[cpu_int_pkg::RD_SERIAL_BIT] = serial_s;
   end

   always_comb begin
      set_word = '0;
      set_word[cpu_int_pkg::SET_MASK_LSB +: 3] = mask_q;
      set_word[cpu_int_pkg::SET_SERIAL_DATA] = serial_out_q;
   end

   always_comb begin
      en_word = '0;
      en_word[cpu_int_pkg::EN_BIT] = ie_q;
   end

   assign rd_word = sel_read_r ? read_word :
                    sel_set_r ? set_word :
                    sel_en_r ? en_word :
                    32'h0000_0000;

   // ----------------------------------------
   // Global enable and saved enable
   // ----------------------------------------
   logic ie_d;
   logic report_saved_d;

   // Acceptance beats a same-cycle enable write: the service disables
   assign ie_d = ack_take ? 1'b0 :
                 en_fire ? w_byte_q[cpu_int_pkg::EN_BIT] :
                 ie_q;

   // A fresh unmaskable service wins over a same-cycle read clearing it
   assign report_saved_d = take_nmi ? 1'b1 :
                           read_fire ? 1'b0 :
                           report_saved_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ie_q <= 1'b0;
         saved_ie_q <= 1'b0;
         report_saved_q <= 1'b0;
      end else begin
         ie_q <= ie_d;
         report_saved_q <= report_saved_d;
         if (take_nmi) begin
            saved_ie_q <= ie_q;
         end
      end
   end

   // ----------------------------------------
   // Edge latch and unmaskable arming
   // ----------------------------------------
   logic edge_latch_d;
   logic nmi_armed_d;

   // Set wins; masking does not stop the latch from catching the edge
   assign edge_latch_d = edge_rise ? 1'b1 :
                         (take_edge | edge_clear_cmd) ? 1'b0 :
                         edge_latch_q;

   // Re-armed by a low level; a taken request disarms until then
   assign nmi_armed_d = ~pins_s.nmi ? 1'b1 :
                        take_nmi ? 1'b0 :
                        nmi_armed_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_latch_q <= 1'b0;
         edge_prev_q <= 1'b0;
         nmi_armed_q <= 1'b0;
      end else begin
         edge_latch_q <= edge_latch_d;
         edge_prev_q <= pins_s.edge_rst;
         nmi_armed_q <= nmi_armed_d;
      end
   end

   // ----------------------------------------
   // Masks and serial output
   // ----------------------------------------
   logic mask_load;
   logic serial_load;

   assign mask_load = set_fire & w_byte_q[cpu_int_pkg::SET_MASK_ENABLE];
   assign serial_load = set_fire & w_byte_q[cpu_int_pkg::SET_SERIAL_ENABLE];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= cpu_int_pkg::MASK_RESET;
         serial_out_q <= cpu_int_pkg::SERIAL_OUT_RESET;
      end else begin
         if (mask_load) begin
            mask_q <= w_byte_q[cpu_int_pkg::SET_MASK_LSB +: 3];
         end
         if (serial_load) begin
            serial_out_q <= w_byte_q[cpu_int_pkg::SET_SERIAL_DATA];
         end
      end
   end

   assign serial_bit_out = serial_out_q;

   // ----------------------------------------
   // Request outputs to the core
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_request <= 1'b0;
         int_vector <= cpu_int_pkg::VEC_NONE;
         int_general <= 1'b0;
         src_q <= cpu_int_pkg::SRC_NONE;
      end else begin
         int_request <= req_d;
         int_vector <= vector_d;
         int_general <= req_d & (src_d == cpu_int_pkg::SRC_GENERAL);
         src_q <= req_d ? src_d : cpu_int_pkg::SRC_NONE;
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   // One write in flight; ready drops once each half is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         aw_addr_q <= '0;
         w_byte_q <= 8'h00;
         w_lane0_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= cpu_int_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_q <= 1'b1;
            awready <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_q <= 1'b1;
            wready <= 1'b0;
            w_byte_q <= wdata[7:0];
            w_lane0_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_mapped ? cpu_int_pkg::RESP_OKAY : cpu_int_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   // The mask-read side effect happens once, when the data is captured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_got_q <= 1'b0;
         arready <= 1'b1;
         ar_addr_q <= '0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= cpu_int_pkg::RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            ar_got_q <= 1'b1;
            arready <= 1'b0;
            ar_addr_q <= araddr;
         end
         if (rd_fire) begin
            ar_got_q <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_mapped ? cpu_int_pkg::RESP_OKAY : cpu_int_pkg::RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule : cpu_int_unit

// ---- tb/cpu_int_unit_sva.sv ----
// Port checks of the interrupt and serial bit unit.
// Assumes binding to cpu_int_unit, one clock domain.
`timescale 1ns/10ps

module cpu_int_unit_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic int_acknowledge_strobe,
   input wire logic int_request,
   input wire logic [7:0] int_vector,
   input wire logic int_general,
   input wire logic serial_bit_out
);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence ack_taken;
      int_acknowledge_strobe && int_request;
   endsequence

   chk_ack_drop: assert property (ack_taken |=> !int_request)
      else $error("request held after acknowledge");
   chk_vec_legal:
      assert property (int_request && !int_general |-> int_vector inside {8'h24, 8'h3C, 8'h34, 8'h2C})
      else $error("illegal restart vector");
   chk_gen_vec: assert property (int_request && int_general |-> int_vector == 8'h00)
      else $error("general request with vector");
   chk_b_wait: assert property (wr_taken |-> ##2 bvalid)
      else $error("write answer late");
   chk_aw_refuse: assert property (wr_taken |=> !awready && !wready)
      else $error("write taken twice");
   chk_r_wait: assert property (arvalid && arready |-> ##2 rvalid)
      else $error("read answer late");
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_reset_out:
      assert property (disable iff (1'b0) !aresetn |=> !int_request && !bvalid && !rvalid)
      else $error("outputs not cleared by reset");
endmodule : cpu_int_unit_chk

// ---- tb/ext_model.sv ----
// Request sources and the core's acknowledge, seen from outside the unit.
// Assumes the unit's clock; acknowledge delay set by dly.
`timescale 1ns/10ps

module ext_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] raise,
   input wire logic nmi_go,
   input wire logic ack_en,
   input wire logic [3:0] dly,
   input wire logic int_request,
   input wire logic [7:0] int_vector,
   output cpu_int_pkg::int_pins_s int_pins,
   output logic int_acknowledge_strobe
);
   // ----------------------------------------
   // Sources and acknowledge
   // ----------------------------------------
   logic nmi_q;
   logic ack_q;
   logic [3:0] cnt_q;
   wire nmi_ack = ack_q && int_request && int_vector == cpu_int_pkg::VEC_NMI;

   assign int_pins = {nmi_q, raise};
   assign int_acknowledge_strobe = ack_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_q <= 1'b0;
         ack_q <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         nmi_q <= nmi_go || (nmi_q && !nmi_ack);
         ack_q <= ack_en && int_request && !ack_q && cnt_q == dly;
         cnt_q <= (int_request && cnt_q != dly) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule : ext_model

// ---- tb/testbench.sv ----
// Self-checking bench of the interrupt and serial bit unit.
// Assumes the unit, its checker and the source model are compiled first.
`timescale 1ns/10ps

bind cpu_int_unit cpu_int_unit_chk chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
   .int_acknowledge_strobe, .int_request, .int_vector, .int_general, .serial_bit_out);

module testbench;
   localparam logic [1:0] OK = cpu_int_pkg::RESP_OKAY;
   localparam logic [1:0] ER = cpu_int_pkg::RESP_SLVERR;
   localparam logic [3:0] A_SET = cpu_int_pkg::OFF_MASK_SET[3:0];
   localparam logic [3:0] A_RD = cpu_int_pkg::OFF_MASK_READ[3:0];
   localparam logic [3:0] A_EN = cpu_int_pkg::OFF_ENABLE[3:0];
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, serial_bit_in, ack_strobe;
   logic int_request, int_general, serial_bit_out, nmi_go, ack_en, b, s;
   logic [3:0] awaddr, araddr, wstrb, raise, dly;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] int_vector;
   cpu_int_pkg::int_pins_s int_pins;
   int err_total, checks, i;
   logic [31:0] exp_q[$];
   string nm_q[$];
   logic [31:0] vt [4] = '{32'h03C, 32'h034, 32'h02C, 32'h100};

   cpu_int_unit dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .int_pins, .serial_bit_in, .int_acknowledge_strobe(ack_strobe), .int_request,
      .int_vector, .int_general, .serial_bit_out);
   ext_model ext_u (.aclk, .aresetn, .raise, .nmi_go, .ack_en, .dly, .int_request,
      .int_vector, .int_pins, .int_acknowledge_strobe(ack_strobe));

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic note(input string nm, input logic [31:0] e);
      nm_q.push_back(nm);
      exp_q.push_back(e);
   endtask : note

   task automatic take(input logic [31:0] g);
      if (exp_q.size() == 0) begin
         err_total++;
         $display("Error unexpected result expected none seen %h", g);
      end else begin
         chk(nm_q.pop_front(), exp_q.pop_front(), g);
      end
   endtask : take

   // Results are taken at the handshake edge itself
   always @(posedge aclk) begin
      if ((rvalid && rready) === 1'b1) take(rdata);
      if ((ack_strobe && int_request) === 1'b1) take({23'h0, int_general, int_vector});
   end

   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Lazy mode leaves one idle cycle before the request
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er, input bit lz);
      bit ta, tw, hs;
      @(posedge aclk);
      if (lz) @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         hs = bvalid && bready;
         if (hs) chk("bresp", {30'h0, er}, {30'h0, bresp});
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= !hs;
      end while (!hs);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er, input bit lz);
      bit ta, hs;
      @(posedge aclk);
      if (lz) @(posedge aclk);
      note("rdata", e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arvalid && arready;
         hs = rvalid && rready;
         if (hs) chk("rresp", {30'h0, er}, {30'h0, rresp});
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         rready <= !hs;
      end while (!hs);
   endtask : rd

   task automatic summarize;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      $display("Error watchdog expected done seen hang");
      summarize();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, serial_bit_in} = '0;
      {nmi_go, ack_en, awaddr, araddr, raise, dly, wdata} = '0;
      wstrb = 4'hF;
      void'($urandom(32'h733CD689));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_RD, 32'h07, OK, 1'b0);
      rd(A_SET, 32'h07, OK, 1'b1);
      rd(4'hC, 32'h0, ER, 1'b0);
      wr(A_RD, 32'h1, ER, 1'b1);
      wstrb <= 4'h0;
      wr(A_EN, 32'h1, OK, 1'b0);
      wstrb <= 4'hF;
      rd(A_EN, 32'h0, OK, 1'b0);
      $display("done: reset and map");
      wr(A_SET, 32'h08, OK, 1'b0);
      raise <= 4'hF;
      repeat (3) @(posedge aclk);
      raise[3] <= 1'b0;
      wr(A_EN, 32'h1, OK, 1'b0);
      repeat (10) @(posedge aclk);
      for (i = 0; i < 4; i++) begin
         dly <= 4'($urandom_range(7));
         note("vector", vt[i]);
         ack_en <= 1'b1;
         while (exp_q.size() != 0) @(posedge aclk);
         @(posedge aclk);
         ack_en <= 1'b0;
         if (i > 0) raise[3-i] <= 1'b0;
         rd(A_EN, 32'h0, OK, 1'b0);
         repeat (8) @(posedge aclk);
         wr(A_EN, 32'h1, OK, 1'b0);
      end
      $display("done: priority");
      wr(A_SET, 32'h0F, OK, 1'b0);
      ack_en <= 1'b1;
      for (i = 1; i >= 0; i--) begin
         wr(A_EN, {31'h0, i[0]}, OK, 1'b0);
         note("vector", 32'h024);
         nmi_go <= 1'b1;
         @(posedge aclk);
         nmi_go <= 1'b0;
         while (exp_q.size() != 0) @(posedge aclk);
         repeat (8) @(posedge aclk);
         rd(A_RD, {28'h0, i[0], 3'h7}, OK, 1'b0);
         rd(A_RD, 32'h07, OK, 1'b0);
      end
      $display("done: unmaskable");
      wr(A_EN, 32'h1, OK, 1'b0);
      raise[3] <= 1'b1;
      repeat (3) @(posedge aclk);
      raise[3] <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(A_RD, 32'h4F, OK, 1'b0);
      wr(A_SET, 32'h10, OK, 1'b0);
      rd(A_RD, 32'h0F, OK, 1'b0);
      $display("done: masked edge");
      for (i = 0; i < 4; i++) begin
         b = 1'($urandom);
         s = 1'($urandom);
         serial_bit_in <= s;
         wr(A_SET, {24'h0, b, 7'h40}, OK, 1'b1);
         @(negedge aclk);
         chk("serial_bit_out", {31'h0, b}, {31'h0, serial_bit_out});
         rd(A_RD, {24'h0, s, 7'h0F}, OK, 1'b1);
         rd(A_SET, {24'h0, b, 7'h07}, OK, 1'b0);
      end
      $display("done: serial bits");
      // Latch an edge with enable already on, then check that reset clears them
      serial_bit_in <= 1'b0;
      raise[3] <= 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b0;
      raise[3] <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_RD, 32'h07, OK, 1'b0);
      rd(A_SET, 32'h07, OK, 1'b0);
      $display("done: mid-run reset");
      summarize();
   end
endmodule : testbench
